// >>> logic/bme_executor.sv
/*
 * Bit-manipulation executor: decodes memory/port bit set and clear,
 * port bit test, interrupt latch masking and port input to accumulator.
 * Assumes instruction bytes arrive one per strobe from the fetch logic,
 * pointer registers come from the same clock domain, pins are async.
 */
// The address-and-strobe port and the register addresses are this design's own decisions.
// Operation
// RULE1: port bit test copies bit into flag
// RULE2: single-byte set bit at pointer address
// RULE3: single-byte clear bit at pointer address
// RULE4: prefixed set bit at page-0 address
// RULE5: prefixed clear bit at page-0 address
// RULE6: prefixed set bit of port register
// RULE7: prefixed clear bit of port register
// RULE8: low-pointer selects port four-seven and bit
// RULE9: enable interrupts, clear latches with zero mask
// RULE10: disable interrupts, clear latches with zero mask
// RULE11: decode separate latch-only clear operation
// RULE12: port input value loads the accumulator
// RULE13: bit writes leave other nibble bits unchanged
// RULE14: latch-only clear keeps master enable unchanged
`timescale 1ns/1ps
module bme_executor
#(
   parameter logic [15:0] OUT_PORT_MASK = 16'h0006
)
(
   input  wire logic                 CLK_SYS_I,
   input  wire logic                 SRST_I,
   input  wire bme_pkg::bme_instr_t  INSTR_I,
   input  wire logic [3:0]           H_PTR_I,
   input  wire logic [3:0]           L_PTR_I,
   input  wire logic [63:0]          PIN_I,
   input  wire bme_pkg::bme_bus_req_t BUS_REQ_I,
   output logic [7:0]                RDATA_O,
   output logic                      TEST_FLAG_O,
   output logic                      IRQ_ENABLE_O,
   output logic [5:0]                IRQ_LATCH_O,
   output logic [3:0]                ACC_O,
   output logic [63:0]               PORT_O
);

   // ****************************************************************
   // state and helpers
   // ****************************************************************
   bme_pkg::bme_state_t r;
   bme_pkg::bme_state_t next_r;

   // output ports read back their register, others read the pins
   function automatic logic [3:0] port_value(
      input logic [15:0][3:0] regs,
      input logic [15:0][3:0] pins,
      input logic [3:0]       idx
   );
      port_value = OUT_PORT_MASK[idx] ? regs[idx] : pins[idx];
   endfunction

   logic       take_fetch;
   logic       take_oper;
   logic [7:0] code;
   logic [1:0] sub;
   logic [1:0] bidx1;
   logic [1:0] bidx2;
   logic [3:0] lo;
   logic [7:0] hl;
   logic [3:0] hl_word;
   logic [3:0] lport;
   logic [3:0] sel_val;
   logic       sel_bit;
   logic       bus_latch_wr;
   logic [5:0] mask;

   assign code         = INSTR_I.code;
   assign take_fetch   = INSTR_I.valid && (r.phase == bme_pkg::BME_FETCH);
   assign take_oper    = INSTR_I.valid && (r.phase == bme_pkg::BME_OPERAND);
   assign sub          = code[7:6];
   assign bidx1        = code[1:0];
   assign bidx2        = code[5:4];
   assign lo           = code[3:0];
   assign mask         = code[5:0];
   assign hl           = {H_PTR_I, L_PTR_I};
   assign hl_word      = r.mem[hl];
   assign lport        = 4'(L_PTR_I[3:2]) + bme_pkg::LPORT_BASE;
   assign sel_val      = port_value(r.port, r.pin_s2, lo);
   assign sel_bit      = sel_val[bidx2];
   assign bus_latch_wr = BUS_REQ_I.wr && (BUS_REQ_I.addr == bme_pkg::REG_LATCH);

   // ****************************************************************
   // next state
   // ****************************************************************
   always_comb
   begin
      next_r        = r;
      next_r.rdata  = 8'h00;
      next_r.pin_s1 = PIN_I;
      next_r.pin_s2 = r.pin_s1;

      case (r.phase)
         bme_pkg::BME_FETCH:
         begin
            if (INSTR_I.valid)
            begin
               if (code == bme_pkg::OP_PFX_IRQ || code == bme_pkg::OP_PFX_MEM ||
                   code == bme_pkg::OP_PFX_IO || code == bme_pkg::OP_PFX_PORT)
               begin
                  next_r.phase  = bme_pkg::BME_OPERAND;
                  next_r.prefix = code;
               end
               else if (code[7:2] == bme_pkg::OP_SET_HL)
                  next_r.mem[hl][bidx1] = 1'b1;                  // see RULE2 see RULE13
               else if (code[7:2] == bme_pkg::OP_CLR_HL)
                  next_r.mem[hl][bidx1] = 1'b0;                  // see RULE3 see RULE13
               else if (code == bme_pkg::OP_SET_LPTR)
                  next_r.port[lport][L_PTR_I[1:0]] = 1'b1;       // see RULE8 see RULE13
               else if (code == bme_pkg::OP_CLR_LPTR)
                  next_r.port[lport][L_PTR_I[1:0]] = 1'b0;       // see RULE8 see RULE13
            end
         end
         bme_pkg::BME_OPERAND:
         begin
            // second byte may lag the prefix by any number of idle cycles
            if (INSTR_I.valid)
            begin
               next_r.phase = bme_pkg::BME_FETCH;
               case (r.prefix)
                  bme_pkg::OP_PFX_MEM:
                  begin
                     if (sub == bme_pkg::SUB_SET)
                        next_r.mem[{4'h0, lo}][bidx2] = 1'b1;     // see RULE4 see RULE13
                     else if (sub == bme_pkg::SUB_CLR)
                        next_r.mem[{4'h0, lo}][bidx2] = 1'b0;     // see RULE5 see RULE13
                  end
                  bme_pkg::OP_PFX_PORT:
                  begin
                     if (sub == bme_pkg::SUB_SET)
                        next_r.port[lo][bidx2] = 1'b1;           // see RULE6 see RULE13
                     else if (sub == bme_pkg::SUB_CLR)
                        next_r.port[lo][bidx2] = 1'b0;           // see RULE7 see RULE13
                     else if (sub == bme_pkg::SUB_COPY_BIT_TO_FLAG)
                        next_r.test_result_flag = sel_bit;       // see RULE1
                  end
                  bme_pkg::OP_PFX_IRQ:
                  begin
                     if (sub == bme_pkg::SUB_ENABLE_AND_MASK_LATCHES)
                        next_r.master_irq_enable = 1'b1;         // see RULE9
                     else if (sub == bme_pkg::SUB_DISABLE_AND_MASK_LATCHES)
                        next_r.master_irq_enable = 1'b0;         // see RULE10
                     if (sub != 2'h0)
                        next_r.irq_latch_vector = r.irq_latch_vector & mask; // see RULE9 see RULE10 see RULE11 see RULE14
                  end
                  bme_pkg::OP_PFX_IO:
                  begin
                     if (code[7:4] == bme_pkg::SUB_IN_ACC)
                        next_r.accumulator_reg = sel_val;        // see RULE12
                  end
                  default:
                  begin
                     next_r.phase = bme_pkg::BME_FETCH;
                  end
               endcase
            end
         end
         default:
         begin
            next_r.phase = bme_pkg::BME_FETCH;
         end
      endcase

      // ****************************************************************
      // register port
      // ****************************************************************
      // a latch request in the same cycle as a masking clear survives
      if (bus_latch_wr)
         next_r.irq_latch_vector = next_r.irq_latch_vector | BUS_REQ_I.wdata[5:0];
      if (BUS_REQ_I.wr && BUS_REQ_I.addr == bme_pkg::REG_MEMADDR)
         next_r.memaddr = BUS_REQ_I.wdata;
      if (BUS_REQ_I.rd)
      begin
         case (BUS_REQ_I.addr)
            bme_pkg::REG_STATUS:
               next_r.rdata = {r.accumulator_reg, 2'h0, r.master_irq_enable, r.test_result_flag};
            bme_pkg::REG_LATCH:
               next_r.rdata = {2'h0, r.irq_latch_vector};
            bme_pkg::REG_MEMADDR:
               next_r.rdata = r.memaddr;
            bme_pkg::REG_MEMDATA:
               next_r.rdata = {4'h0, r.mem[r.memaddr]};
            default:
               next_r.rdata = 8'h00;
         endcase
      end
   end

   always_ff @(posedge CLK_SYS_I)
   begin
      if (SRST_I)
         r <= bme_pkg::RESET_STATE;
      else
         r <= next_r;
   end

   assign RDATA_O      = r.rdata;
   assign TEST_FLAG_O  = r.test_result_flag;
   assign IRQ_ENABLE_O = r.master_irq_enable;
   assign IRQ_LATCH_O  = r.irq_latch_vector;
   assign ACC_O        = r.accumulator_reg;
   assign PORT_O       = r.port;

   // ****************************************************************
   // assertions
   // ****************************************************************
   default clocking cb @(posedge CLK_SYS_I); endclocking
   default disable iff (SRST_I);

   sequence s_prefix_taken;
      take_fetch && (code == bme_pkg::OP_PFX_PORT || code == bme_pkg::OP_PFX_MEM ||
                     code == bme_pkg::OP_PFX_IRQ || code == bme_pkg::OP_PFX_IO);
   endsequence

   sequence s_oper(logic [7:0] p, logic [1:0] s);
      take_oper && r.prefix == p && sub == s;
   endsequence

   sequence s_read(logic [2:0] a);
      BUS_REQ_I.rd && BUS_REQ_I.addr == a;
   endsequence

   prefix_wait_a: assert property (s_prefix_taken |=> r.phase == bme_pkg::BME_OPERAND && r.prefix == $past(code))
      else $error("prefix not held for operand byte");

   copy_bit_to_flag_copy_a: assert property (s_oper(bme_pkg::OP_PFX_PORT, bme_pkg::SUB_COPY_BIT_TO_FLAG) |=> // see RULE1
      TEST_FLAG_O == $past(sel_bit) && r.phase == bme_pkg::BME_FETCH)
      else $error("port bit test result wrong");

   set_hl_a: assert property ((take_fetch && code[7:2] == bme_pkg::OP_SET_HL) |=> // see RULE2
      r.mem[$past(hl)][$past(bidx1)] == 1'b1)
      else $error("pointer set bit failed");

   clr_hl_a: assert property ((take_fetch && code[7:2] == bme_pkg::OP_CLR_HL) |=> // see RULE3
      r.mem[$past(hl)][$past(bidx1)] == 1'b0)
      else $error("pointer clear bit failed");

   set_direct_a: assert property (s_oper(bme_pkg::OP_PFX_MEM, bme_pkg::SUB_SET) |=> // see RULE4
      r.mem[{4'h0, $past(lo)}][$past(bidx2)] == 1'b1)
      else $error("direct set bit failed");

   clr_direct_a: assert property (s_oper(bme_pkg::OP_PFX_MEM, bme_pkg::SUB_CLR) |=> // see RULE5
      r.mem[{4'h0, $past(lo)}][$past(bidx2)] == 1'b0)
      else $error("direct clear bit failed");

   set_port_a: assert property (s_oper(bme_pkg::OP_PFX_PORT, bme_pkg::SUB_SET) |=> // see RULE6
      r.port[$past(lo)][$past(bidx2)] == 1'b1)
      else $error("port set bit failed");

   clr_port_a: assert property (s_oper(bme_pkg::OP_PFX_PORT, bme_pkg::SUB_CLR) |=> // see RULE7
      r.port[$past(lo)][$past(bidx2)] == 1'b0)
      else $error("port clear bit failed");

   lptr_port_a: assert property ((take_fetch && (code == bme_pkg::OP_SET_LPTR || code == bme_pkg::OP_CLR_LPTR)) |=> // see RULE8
      r.port[{2'h1, $past(L_PTR_I[3:2])}][$past(L_PTR_I[1:0])] == ($past(code) == bme_pkg::OP_SET_LPTR))
      else $error("pointer port bit wrong");

   ei_mask_a: assert property ((s_oper(bme_pkg::OP_PFX_IRQ, bme_pkg::SUB_ENABLE_AND_MASK_LATCHES) and !bus_latch_wr) |=> // see RULE9
      IRQ_ENABLE_O && IRQ_LATCH_O == ($past(IRQ_LATCH_O) & $past(mask)))
      else $error("enable with latch mask wrong");

   di_mask_a: assert property ((s_oper(bme_pkg::OP_PFX_IRQ, bme_pkg::SUB_DISABLE_AND_MASK_LATCHES) and !bus_latch_wr) |=> // see RULE10
      !IRQ_ENABLE_O && IRQ_LATCH_O == ($past(IRQ_LATCH_O) & $past(mask)))
      else $error("disable with latch mask wrong");

   latch_only_a: assert property ((s_oper(bme_pkg::OP_PFX_IRQ, bme_pkg::SUB_CLRIL) and !bus_latch_wr) |=> // see RULE11
      $stable(IRQ_ENABLE_O) && IRQ_LATCH_O == ($past(IRQ_LATCH_O) & $past(mask))) // see RULE14
      else $error("latch-only clear wrong");

   in_acc_a: assert property ((take_oper && r.prefix == bme_pkg::OP_PFX_IO && code[7:4] == bme_pkg::SUB_IN_ACC) |=> // see RULE12
      ACC_O == $past(sel_val))
      else $error("port input not in accumulator");

   rmw_keep_a: assert property ((take_fetch && code[7:3] == 5'h0A) |=> // see RULE13
      (r.mem[$past(hl)] & ~(4'h1 << $past(bidx1))) == ($past(hl_word) & ~(4'h1 << $past(bidx1))))
      else $error("other nibble bits disturbed");

   latch_set_wins_a: assert property (bus_latch_wr |=> (IRQ_LATCH_O & $past(BUS_REQ_I.wdata[5:0])) == $past(BUS_REQ_I.wdata[5:0]))
      else $error("latch request lost");

   oper_ends_a: assert property (take_oper |=> r.phase == bme_pkg::BME_FETCH)
      else $error("operand byte did not end the op");

   irq_nop_a: assert property ((s_oper(bme_pkg::OP_PFX_IRQ, 2'h0) and !bus_latch_wr) |=> // see RULE11
      $stable(IRQ_ENABLE_O) && $stable(IRQ_LATCH_O))
      else $error("idle interrupt sub-op changed state");

   status_read_a: assert property (s_read(bme_pkg::REG_STATUS) |=>
      RDATA_O == {$past(ACC_O), 2'h0, $past(IRQ_ENABLE_O), $past(TEST_FLAG_O)})
      else $error("status read data wrong");

   latch_read_a: assert property (s_read(bme_pkg::REG_LATCH) |=> RDATA_O == {2'h0, $past(IRQ_LATCH_O)})
      else $error("latch read data wrong");

   memaddr_wr_a: assert property ((BUS_REQ_I.wr && BUS_REQ_I.addr == bme_pkg::REG_MEMADDR) |=>
      r.memaddr == $past(BUS_REQ_I.wdata))
      else $error("memory address write lost");

   rdata_idle_a: assert property (!BUS_REQ_I.rd |=> RDATA_O == 8'h00)
      else $error("read data outside read cycle");

endmodule

// >>> logic/bme_pkg.sv
/*
 * Package for the bit-manipulation executor: opcodes, field codes,
 * register indices, reset values, carrier structs and the state record.
 * Assumes a single 200 MHz clock domain and a synchronous reset.
 */
package bme_pkg;

   // ****************************************************************
   // sizes
   // ****************************************************************
   localparam int MEM_WORDS  = 256;
   localparam int PORT_COUNT = 16;
   localparam int LATCH_BITS = 6;

   // ****************************************************************
   // opcodes and second-byte fields
   // ****************************************************************
   localparam logic [7:0] OP_PFX_IRQ   = 8'h36;
   localparam logic [7:0] OP_PFX_MEM   = 8'h39;
   localparam logic [7:0] OP_PFX_IO    = 8'h3A;
   localparam logic [7:0] OP_PFX_PORT  = 8'h3B;
   localparam logic [7:0] OP_SET_LPTR  = 8'h34;
   localparam logic [7:0] OP_CLR_LPTR  = 8'h35;
   localparam logic [5:0] OP_SET_HL    = 6'h14;
   localparam logic [5:0] OP_CLR_HL    = 6'h15;
   localparam logic [1:0] SUB_SET      = 2'h0;
   localparam logic [1:0] SUB_CLR      = 2'h1;
   localparam logic [1:0] SUB_COPY_BIT_TO_FLAG    = 2'h3;
   localparam logic [1:0] SUB_ENABLE_AND_MASK_LATCHES    = 2'h1;
   localparam logic [1:0] SUB_DISABLE_AND_MASK_LATCHES    = 2'h2;
   localparam logic [1:0] SUB_CLRIL    = 2'h3;
   localparam logic [3:0] SUB_IN_ACC   = 4'h2;
   localparam logic [3:0] LPORT_BASE   = 4'h4;

   // ****************************************************************
   // register indices on the plain register port
   // ****************************************************************
   localparam logic [2:0] REG_STATUS   = 3'h0;
   localparam logic [2:0] REG_LATCH    = 3'h1;
   localparam logic [2:0] REG_MEMADDR  = 3'h2;
   localparam logic [2:0] REG_MEMDATA  = 3'h3;

   // ****************************************************************
   // types
   // ****************************************************************
   typedef enum logic [1:0] {BME_FETCH = 2'h0, BME_OPERAND = 2'h1} bme_phase_t;

   typedef struct packed {
      logic       wr;
      logic       rd;
      logic [2:0] addr;
      logic [7:0] wdata;
   } bme_bus_req_t;

   typedef struct packed {
      logic       valid;
      logic [7:0] code;
   } bme_instr_t;

   typedef struct packed {
      bme_phase_t                         phase;
      logic [7:0]                         prefix;
      logic                               test_result_flag;
      logic                               master_irq_enable;
      logic [LATCH_BITS-1:0]              irq_latch_vector;
      logic [3:0]                         accumulator_reg;
      logic [MEM_WORDS-1:0][3:0]          mem;
      logic [PORT_COUNT-1:0][3:0]         port;
      logic [PORT_COUNT-1:0][3:0]         pin_s1;
      logic [PORT_COUNT-1:0][3:0]         pin_s2;
      logic [7:0]                         memaddr;
      logic [7:0]                         rdata;
   } bme_state_t;

   localparam bme_state_t RESET_STATE = '0;

endpackage

// >>> bench/test_bit_manipulation_executor.sv
/*
 * Self-checking bench for the bit-manipulation executor: memory and port
 * bit set/clear, port bit test, port input, interrupt latch masking.
 * Assumes the executor's default output-port mask (ports 1 and 2 output)
 * and the register map of its package; bench drives all ports itself.
 */
`timescale 1ns/1ps
`define CHK(got, exp) begin check_count++; if ((got) !== (exp)) begin n_fail++; \
   $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp); end end
module test_bit_manipulation_executor;
   logic                  clk_sys = 1'b0;
   logic                  srst    = 1'b1;
   bme_pkg::bme_instr_t   instr   = '0;
   logic [3:0]            h_ptr   = 4'h0;
   logic [3:0]            l_ptr   = 4'h0;
   logic [63:0]           pin     = 64'h0;
   bme_pkg::bme_bus_req_t bus_req = '0;
   logic [7:0]            rdata;
   logic                  test_flag;
   logic                  irq_en;
   logic [5:0]            irq_latch;
   logic [3:0]            acc;
   logic [63:0]           port;
   int                    n_fail      = 0;
   int                    check_count = 0;
   logic [3:0]            e;
   logic [3:0]            v;
   logic [7:0]            d;
   localparam logic [3:0] PIN5 = 4'hA;

   bme_executor bme_executor_i (
      .CLK_SYS_I    (clk_sys),
      .SRST_I       (srst),
      .INSTR_I      (instr),
      .H_PTR_I      (h_ptr),
      .L_PTR_I      (l_ptr),
      .PIN_I        (pin),
      .BUS_REQ_I    (bus_req),
      .RDATA_O      (rdata),
      .TEST_FLAG_O  (test_flag),
      .IRQ_ENABLE_O (irq_en),
      .IRQ_LATCH_O  (irq_latch),
      .ACC_O        (acc),
      .PORT_O       (port)
   );

   initial
   begin
      forever #2.5 clk_sys = ~clk_sys;
   end

   // ****************************************************************
   // access tasks
   // ****************************************************************
   task automatic put(input logic [7:0] b);
      @(posedge clk_sys);
      instr <= '{valid: 1'b1, code: b};
   endtask

   // drops the strobe; results of the last byte are settled on return
   task automatic done();
      @(posedge clk_sys);
      instr <= '0;
      #1;
   endtask

   task automatic op1(input logic [7:0] b);
      put(b);
      done();
   endtask

   task automatic op2(input logic [7:0] p, input logic [7:0] o);
      put(p);
      put(o);
      done();
   endtask

   task automatic bus_wr(input logic [2:0] a, input logic [7:0] w);
      @(posedge clk_sys);
      bus_req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: w};
      @(posedge clk_sys);
      bus_req <= '0;
   endtask

   task automatic bus_rd(input logic [2:0] a, output logic [7:0] r);
      @(posedge clk_sys);
      bus_req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
      @(posedge clk_sys);
      bus_req <= '0;
      #1;
      r = rdata;
   endtask

   task automatic mem_rd(input logic [7:0] a, output logic [3:0] r);
      logic [7:0] t;
      bus_wr(bme_pkg::REG_MEMADDR, a);
      bus_rd(bme_pkg::REG_MEMDATA, t);
      r = t[3:0];
   endtask

   task automatic close_out();
      $display("checks %0d mismatches %0d", check_count, n_fail);
      if (n_fail == 0 && check_count > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask

   // ****************************************************************
   // watchdog
   // ****************************************************************
   initial
   begin
      repeat (20000) @(posedge clk_sys);
      n_fail++;
      close_out();
   end

   // ****************************************************************
   // tests
   // ****************************************************************
   initial
   begin
      repeat (10) @(posedge clk_sys);
      srst  <= 1'b0;
      h_ptr <= 4'h5;
      l_ptr <= 4'hA;
      e = 4'h0;
      for (int b = 0; b < 4; b++)
      begin
         op1({bme_pkg::OP_SET_HL, b[1:0]});
         e[b] = 1'b1;
         mem_rd(8'h5A, v);
         `CHK(v, e)
      end
      op1({bme_pkg::OP_CLR_HL, 2'd1});
      e[1] = 1'b0;
      mem_rd(8'h5A, v);
      `CHK(v, e)
      // idle gap between prefix and operand on the first one
      put(bme_pkg::OP_PFX_MEM);
      done();
      put({2'b00, 2'd0, 4'hF});
      done();
      op2(bme_pkg::OP_PFX_MEM, {2'b00, 2'd3, 4'hF});
      mem_rd(8'h0F, v);
      `CHK(v, 4'h9)
      op2(bme_pkg::OP_PFX_MEM, {2'b01, 2'd0, 4'hF});
      mem_rd(8'h0F, v);
      `CHK(v, 4'h8)
      mem_rd(8'h5A, v);
      `CHK(v, e)
      bus_rd(bme_pkg::REG_MEMADDR, d);
      `CHK(d, 8'h5A)
      e = 4'h0;
      for (int b = 0; b < 4; b++)
      begin
         op2(bme_pkg::OP_PFX_PORT, {2'b00, b[1:0], 4'h3});
         e[b] = 1'b1;
         `CHK(port[15:12], e)
      end
      op2(bme_pkg::OP_PFX_PORT, {2'b01, 2'd2, 4'h3});
      `CHK(port[15:12], 4'hB)
      `CHK(port[11:0], 12'h000)
      @(posedge clk_sys);
      l_ptr <= 4'b1110;
      op1(bme_pkg::OP_SET_LPTR);
      `CHK(port[31:28], 4'h4)
      @(posedge clk_sys);
      l_ptr <= 4'b0001;
      op1(bme_pkg::OP_SET_LPTR);
      `CHK(port[19:16], 4'h2)
      @(posedge clk_sys);
      l_ptr <= 4'b1110;
      op1(bme_pkg::OP_CLR_LPTR);
      `CHK(port[31:28], 4'h0)
      `CHK(port[19:16], 4'h2)
      // pins pass a two-flop sync, so let them settle first
      @(posedge clk_sys);
      pin <= {40'h0, PIN5, 20'h0};
      repeat (3) @(posedge clk_sys);
      for (int b = 0; b < 4; b++)
      begin
         op2(bme_pkg::OP_PFX_PORT, {2'b11, b[1:0], 4'h5});
         `CHK(test_flag, PIN5[b])
      end
      op2(bme_pkg::OP_PFX_PORT, {2'b00, 2'd3, 4'h2});
      op2(bme_pkg::OP_PFX_PORT, {2'b11, 2'd3, 4'h2});
      `CHK(test_flag, 1'b1)
      op2(bme_pkg::OP_PFX_IO, {bme_pkg::SUB_IN_ACC, 4'h5});
      `CHK(acc, PIN5)
      op2(bme_pkg::OP_PFX_IO, {bme_pkg::SUB_IN_ACC, 4'h2});
      `CHK(acc, 4'h8)
      bus_wr(3'h7, 8'hFF);
      bus_rd(bme_pkg::REG_STATUS, d);
      `CHK(d, 8'h81)
      bus_wr(bme_pkg::REG_LATCH, 8'h3F);
      op2(bme_pkg::OP_PFX_IRQ, {bme_pkg::SUB_ENABLE_AND_MASK_LATCHES, 6'h2A});
      `CHK(irq_en, 1'b1)
      `CHK(irq_latch, 6'h2A)
      // sub-op 00 after the interrupt prefix must touch nothing
      op2(bme_pkg::OP_PFX_IRQ, {2'b00, 6'h00});
      `CHK(irq_latch, 6'h2A)
      `CHK(irq_en, 1'b1)
      bus_wr(bme_pkg::REG_LATCH, 8'h3F);
      op2(bme_pkg::OP_PFX_IRQ, {bme_pkg::SUB_CLRIL, 6'h0F});
      `CHK(irq_latch, 6'h0F)
      `CHK(irq_en, 1'b1)
      op2(bme_pkg::OP_PFX_IRQ, {bme_pkg::SUB_DISABLE_AND_MASK_LATCHES, 6'h33});
      `CHK(irq_en, 1'b0)
      bus_rd(bme_pkg::REG_LATCH, d);
      `CHK(d, 8'h03)
      bus_wr(bme_pkg::REG_LATCH, 8'h3F);
      op2(bme_pkg::OP_PFX_IRQ, {bme_pkg::SUB_CLRIL, 6'h3C});
      `CHK(irq_latch, 6'h3C)
      `CHK(irq_en, 1'b0)
      close_out();
   end
endmodule
